// [rtl/stc_map.svh]
`ifndef STC_MAP_SVH
`define STC_MAP_SVH

// register byte offsets
`define STC_ADDR_W       5
`define STC_OFF_CTRL     5'h00
`define STC_OFF_STAT     5'h04
`define STC_OFF_COUNT_VALUE_LOW     5'h08
`define STC_OFF_COMPARE_VALUE_LOW     5'h10
`define STC_OFF_ISTAT    5'h14
`define STC_OFF_IMASK    5'h18

// tick_control fields
`define STC_CTRL_EN      0
`define STC_CTRL_IE      1
`define STC_CTRL_CLK     2
`define STC_CTRL_RELOAD  3
`define STC_CTRL_DOWN    4
`define STC_CTRL_SWI     31

// tick_status fields
`define STC_STAT_FLAG    0
`define STC_STAT_SWI     31

// interrupt status and mask fields
`define STC_IRQ_CMP      0
`define STC_IRQ_SWI      1
`define STC_IRQ_W        2

// reset values
`define STC_RST_WORD     32'h0000_0000
`define STC_RST_IRQ      2'h0

// timebase divider
`define STC_DIV_W        3
`define STC_DIV_LAST     3'h7

`endif

// [rtl/stc_pkg.sv]
`default_nettype none
`include "stc_map.svh"

package stc_pkg;

    typedef logic [31:0] stc_word_t;

    typedef struct packed {
        logic      ack;
        stc_word_t rdata;
    } stc_slv_state_t;

    typedef struct packed {
        logic [`STC_DIV_W-1:0] cnt;
    } stc_div_state_t;

    typedef struct packed {
        logic                  soft_irq_trigger;
        logic                  count_down;
        logic                  auto_reload_enable;
        logic                  timebase_select;
        logic                  counter_irq_enable;
        logic                  counter_enable_bit;
        logic                  compare_flag;
        stc_word_t             count_value_low;
        stc_word_t             compare_value_low;
        logic [`STC_IRQ_W-1:0] irq_status;
        logic [`STC_IRQ_W-1:0] irq_mask;
        logic                  swi_prev;
    } stc_core_state_t;

endpackage

`default_nettype wire

// [rtl/stc_bus_if.sv]
`timescale 1ns/100ps
`default_nettype none

interface stc_bus_if;
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rmux;
    logic [31:0] rcap;

    modport slave (output wr, rd, addr, wdata, be, rcap, input rmux);
    modport regs  (input wr, rd, addr, wdata, be, rcap, output rmux);
endinterface

`default_nettype wire

// [rtl/stc_prescaler.sv]
`timescale 1ns/100ps
`default_nettype none
`include "stc_map.svh"

module stc_prescaler
    import stc_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // control
    input  wire logic run,
    output logic      tick
);

    stc_div_state_t s_q;
    stc_div_state_t s_d;

    // one tick every eighth cycle while running
    always_comb begin
        s_d = s_q;
        if (run) begin
            s_d.cnt = s_q.cnt + `STC_DIV_W'(1);
        end else begin
            s_d.cnt = '0;
        end
    end

    assign tick = run && (s_q.cnt == `STC_DIV_LAST);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

`default_nettype wire

// [rtl/stc_avl_slave.sv]
`timescale 1ns/100ps
`default_nettype none

module stc_avl_slave
    import stc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // register side
    stc_bus_if.slave         bus
);

    stc_slv_state_t s_q;
    stc_slv_state_t s_d;

    // one wait cycle, read data captured in it
    always_comb begin
        s_d = s_q;
        s_d.ack = (avs_read || avs_write) && !s_q.ack;
        if (avs_read && !s_q.ack) begin
            s_d.rdata = bus.rmux;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
    assign avs_readdata    = s_q.rdata;
    assign bus.wr          = avs_write && s_q.ack;
    assign bus.rd          = avs_read && s_q.ack;
    assign bus.addr        = avs_address;
    assign bus.wdata       = avs_writedata;
    assign bus.be          = avs_byteenable;
    assign bus.rcap        = s_q.rdata;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

`default_nettype wire

// [rtl/stc_tick_counter.sv]
// Operation
// RL1 - The counter advances on each timebase tick while the enable bit is 1 and holds its value while it is 0.
// RL2 - The direction bit set to 1 makes the counter count down, set to 0 makes it count up.
// RL3 - With auto reload on, up-counting restarts from 0 at the compare value and down-counting from the compare value at 0.
// RL4 - The timebase select bit picks the bus clock when 1 and the bus clock divided by 8 when 0.
// RL5 - The counter interrupt enable bit allows the counter interrupt when 1 and blocks it when 0.
// RL6 - The compare flag is set when an up-count reaches the compare value or a down-count reaches 0.
// RL7 - Writing 0 clears the compare flag and writing 1 leaves it unchanged.
// RL8 - The software trigger bit in the control word raises the software interrupt while it is 1.
// RL9 - Software clears the software trigger in its handler, or the interrupt stays asserted.
// RL10 - Bit 31 of the status word is the same software trigger and reads and writes the same state.
// RL11 - The count value register shows the running counter and is readable and writable.
// RL12 - The compare register holds the reload and compare value and is readable and writable.
// RL13 - The counter interrupt is asserted while the compare flag is set and the interrupt enable bit is 1.
// RL14 - Reserved bits of the control and status words read as zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none
`include "stc_map.svh"

module stc_tick_counter
    import stc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // avalon-mm register port
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // interrupt requests
    output logic             counter_irq,
    output logic             software_interrupt,
    output logic             irq
);

    stc_core_state_t s_q;
    stc_core_state_t s_d;

    logic div_tick;
    logic tick;
    logic up_reach;
    logic dn_reach;
    logic reach;
    logic swi_rise;

    stc_word_t cnt_step;
    stc_word_t rd_word;

    stc_bus_if bus ();

    // address decode, used by every register
    function automatic logic stc_hit(
        input logic [4:0] addr,
        input logic [4:0] off
    );
        stc_hit = (addr == off);
    endfunction

    // byte lane merge of a write into an old word
    function automatic stc_word_t stc_merge(
        input stc_word_t  old_w,
        input stc_word_t  new_w,
        input logic [3:0] be
    );
        stc_word_t res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        stc_merge = res;
    endfunction

    // control word as software sees it
    function automatic stc_word_t stc_ctrl_word(
        input stc_core_state_t st
    );
        stc_word_t w;
        w = `STC_RST_WORD;
        w[`STC_CTRL_EN]     = st.counter_enable_bit;
        w[`STC_CTRL_IE]     = st.counter_irq_enable;
        w[`STC_CTRL_CLK]    = st.timebase_select;
        w[`STC_CTRL_RELOAD] = st.auto_reload_enable;
        w[`STC_CTRL_DOWN]   = st.count_down;
        w[`STC_CTRL_SWI]    = st.soft_irq_trigger;
        stc_ctrl_word = w;
    endfunction

    // status word as software sees it
    function automatic stc_word_t stc_stat_word(
        input stc_core_state_t st
    );
        stc_word_t w;
        w = `STC_RST_WORD;
        w[`STC_STAT_FLAG] = st.compare_flag;
        w[`STC_STAT_SWI]  = st.soft_irq_trigger;
        stc_stat_word = w;
    endfunction

    // read multiplexer, unmapped offsets read as zero
    function automatic stc_word_t stc_read_mux(
        input stc_core_state_t st,
        input logic [4:0]      addr
    );
        stc_word_t w;
        w = `STC_RST_WORD;
        if (stc_hit(addr, `STC_OFF_CTRL)) begin
            w = stc_ctrl_word(st); // [RL14]
        end else if (stc_hit(addr, `STC_OFF_STAT)) begin
            w = stc_stat_word(st); // [RL14]
        end else if (stc_hit(addr, `STC_OFF_COUNT_VALUE_LOW)) begin
            w = st.count_value_low; // [RL11]
        end else if (stc_hit(addr, `STC_OFF_COMPARE_VALUE_LOW)) begin
            w = st.compare_value_low; // [RL12]
        end else if (stc_hit(addr, `STC_OFF_ISTAT)) begin
            w[`STC_IRQ_W-1:0] = st.irq_status;
        end else if (stc_hit(addr, `STC_OFF_IMASK)) begin
            w[`STC_IRQ_W-1:0] = st.irq_mask;
        end
        stc_read_mux = w;
    endfunction

    // bus slave with one wait cycle
    stc_avl_slave u_slave (
        .ref_clk         (ref_clk),
        .rst             (rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .bus             (bus)
    );

    // divide by eight timebase, idle when not needed
    stc_prescaler u_div (
        .ref_clk (ref_clk),
        .rst     (rst),
        .run     (s_q.counter_enable_bit && !s_q.timebase_select),
        .tick    (div_tick)
    );

    assign rd_word  = stc_read_mux(s_q, bus.addr);
    assign bus.rmux = rd_word;

    // timebase selection
    assign tick = s_q.counter_enable_bit && (s_q.timebase_select || div_tick); // [RL1] [RL4]

    // value that the next tick would produce without reload
    assign cnt_step = s_q.count_down ? (s_q.count_value_low - 32'h0000_0001) :
                                       (s_q.count_value_low + 32'h0000_0001); // [RL2]

    // reaching the compare point on this tick
    assign up_reach = !s_q.count_down && (cnt_step == s_q.compare_value_low);
    assign dn_reach = s_q.count_down && (cnt_step == `STC_RST_WORD);
    assign reach    = tick && (up_reach || dn_reach); // [RL6]

    // rising edge of the software trigger
    assign swi_rise = s_q.soft_irq_trigger && !s_q.swi_prev;

    always_comb begin
        s_d = s_q;
        s_d.swi_prev = s_q.soft_irq_trigger;

        // control register write
        if (bus.wr && stc_hit(bus.addr, `STC_OFF_CTRL)) begin
            if (bus.be[0]) begin
                s_d.counter_enable_bit = bus.wdata[`STC_CTRL_EN]; // [RL1]
                s_d.counter_irq_enable = bus.wdata[`STC_CTRL_IE]; // [RL5]
                s_d.timebase_select    = bus.wdata[`STC_CTRL_CLK]; // [RL4]
                s_d.auto_reload_enable = bus.wdata[`STC_CTRL_RELOAD]; // [RL3]
                s_d.count_down         = bus.wdata[`STC_CTRL_DOWN]; // [RL2]
            end
            if (bus.be[3]) begin
                s_d.soft_irq_trigger = bus.wdata[`STC_CTRL_SWI]; // [RL8]
            end
        end

        // status register write
        if (bus.wr && stc_hit(bus.addr, `STC_OFF_STAT)) begin
            if (bus.be[0] && !bus.wdata[`STC_STAT_FLAG]) begin
                s_d.compare_flag = 1'b0; // [RL7]
            end
            if (bus.be[3]) begin
                s_d.soft_irq_trigger = bus.wdata[`STC_STAT_SWI]; // [RL10]
            end
        end

        // compare register write
        if (bus.wr && stc_hit(bus.addr, `STC_OFF_COMPARE_VALUE_LOW)) begin
            s_d.compare_value_low = stc_merge(s_q.compare_value_low, bus.wdata, bus.be); // [RL12]
        end

        // counting, a software write to the count wins over a tick
        if (bus.wr && stc_hit(bus.addr, `STC_OFF_COUNT_VALUE_LOW)) begin
            s_d.count_value_low = stc_merge(s_q.count_value_low, bus.wdata, bus.be); // [RL11]
        end else if (tick) begin
            if (s_q.auto_reload_enable && !s_q.count_down &&
                (s_q.count_value_low == s_q.compare_value_low)) begin
                s_d.count_value_low = `STC_RST_WORD; // [RL3]
            end else if (s_q.auto_reload_enable && s_q.count_down &&
                         (s_q.count_value_low == `STC_RST_WORD)) begin
                s_d.count_value_low = s_q.compare_value_low; // [RL3]
            end else begin
                s_d.count_value_low = cnt_step; // [RL1] [RL2]
            end
        end

        // compare flag set wins over a clear in the same cycle
        if (reach) begin
            s_d.compare_flag = 1'b1; // [RL6]
        end

        // interrupt mask write
        if (bus.wr && stc_hit(bus.addr, `STC_OFF_IMASK) && bus.be[0]) begin
            s_d.irq_mask = bus.wdata[`STC_IRQ_W-1:0];
        end

        // read clears only the status bits that were returned
        if (bus.rd && stc_hit(bus.addr, `STC_OFF_ISTAT)) begin
            s_d.irq_status = s_q.irq_status & ~bus.rcap[`STC_IRQ_W-1:0];
        end

        // new events set sticky bits after the clear
        if (reach) begin
            s_d.irq_status[`STC_IRQ_CMP] = 1'b1;
        end
        if (swi_rise) begin
            s_d.irq_status[`STC_IRQ_SWI] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // interrupt outputs
    assign counter_irq        = s_q.compare_flag && s_q.counter_irq_enable; // [RL5] [RL13]
    assign software_interrupt = s_q.soft_irq_trigger; // [RL8] [RL9]
    assign irq                = |(s_q.irq_status & s_q.irq_mask);

endmodule

`default_nettype wire

// [verification/stc_checker.sv]
`timescale 1ns/100ps
`default_nettype none

module stc_checker
    import stc_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // register port
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // interrupts
    input wire logic        counter_irq,
    input wire logic        software_interrupt,
    input wire logic        irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic wr_ok;
    logic rd_ok;
    assign wr_ok = avs_write && !avs_waitrequest;
    assign rd_ok = avs_read && !avs_waitrequest;

    a_swi_ctrl_wr: assert property (
        wr_ok && avs_address == 5'h00 && avs_byteenable[3] |=> software_interrupt == $past(avs_writedata[31]))
        else $error("soft trigger not taken from control write");
    a_swi_stat_wr: assert property (
        wr_ok && avs_address == 5'h04 && avs_byteenable[3] |=> software_interrupt == $past(avs_writedata[31]))
        else $error("soft trigger not taken from status write");
    a_swi_cause: assert property (
        $changed(software_interrupt) |-> $past(wr_ok))
        else $error("soft trigger changed without a write");
    a_cirq_off: assert property (
        wr_ok && avs_address == 5'h00 && avs_byteenable[0] && !avs_writedata[1] |=> !counter_irq)
        else $error("counter irq left on with enable off");
    a_flag_w1: assert property (
        wr_ok && avs_address == 5'h04 && avs_byteenable[0] && avs_writedata[0] |=> !$fell(counter_irq))
        else $error("write of one cleared the flag");
    a_ctrl_rsvd: assert property (
        rd_ok && avs_address == 5'h00 |-> avs_readdata[30:5] == 26'h0)
        else $error("control reserved bits not zero");
    a_stat_rsvd: assert property (
        rd_ok && avs_address == 5'h04 |-> avs_readdata[30:1] == 30'h0)
        else $error("status reserved bits not zero");
    a_stat_swi_rd: assert property (
        rd_ok && avs_address == 5'h04 |-> avs_readdata[31] == software_interrupt)
        else $error("status bit 31 differs from soft trigger");
    a_one_wait: assert property (
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read not answered after one wait");

    c_cmp: cover property ($rose(counter_irq));
    c_irq: cover property ($rose(irq));
    c_istat: cover property (rd_ok && avs_address == 5'h14 && avs_readdata != 32'h0);
endmodule

bind stc_tick_counter stc_checker chk_u (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .counter_irq, .software_interrupt, .irq);

`default_nettype wire

// [verification/tb_system_tick_counter.sv]
`timescale 1ns/100ps
`default_nettype none

module tb_system_tick_counter;
    import stc_pkg::*;
    logic        ref_clk;
    logic        rst;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        counter_irq;
    logic        software_interrupt;
    logic        irq;
    logic [31:0] r;
    int          fail_count;
    int          tests_run;

    stc_tick_counter dut_u (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .counter_irq, .software_interrupt, .irq);

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic complete_run;
        if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", n, exp, got);
        end
    endtask

    // one avalon access, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
        int i;
        @(posedge ref_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= b;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // let the accepted access land before the caller looks at outputs
        @(posedge ref_clk);
        if (i == 20) begin
            fail_count++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 4'hF);
    endtask

    task automatic rd(input logic [4:0] a);
        acc(1'b0, a, 32'h0, 4'hF);
    endtask

    task automatic wait_cirq;
        int i;
        for (i = 0; i < 200; i++) begin
            @(posedge ref_clk);
            if (counter_irq === 1'b1) break;
        end
        if (i == 200) begin
            fail_count++;
            complete_run();
        end
    endtask

    task automatic t_reset;
        logic [4:0] al [7] = '{5'h00, 5'h04, 5'h08, 5'h10, 5'h14, 5'h18, 5'h0C};
        for (int k = 0; k < 7; k++) begin
            rd(al[k]);
            chk("reset word", r, 32'h0);
        end
    endtask

    task automatic t_regs;
        wr(5'h00, 32'hFFFF_FFFE);
        rd(5'h00);
        chk("ctrl rb", r, 32'h8000_001E);
        chk("swi on", software_interrupt, 1'b1);
        rd(5'h04);
        chk("stat swi", r, 32'h8000_0000);
        wr(5'h04, 32'h0);
        chk("swi off", software_interrupt, 1'b0);
        rd(5'h00);
        chk("ctrl shared", r, 32'h0000_001E);
        wr(5'h00, 32'h0);
        wr(5'h10, 32'hA5A5_5A5A);
        rd(5'h10);
        chk("cmp rb", r, 32'hA5A5_5A5A);
        wr(5'h08, 32'h1234_5678);
        acc(1'b1, 5'h08, 32'hFFFF_FFFF, 4'h1);
        rd(5'h08);
        chk("cnt lane", r, 32'h1234_56FF);
    endtask

    task automatic t_up;
        logic [31:0] c;
        wr(5'h10, 32'h3);
        wr(5'h08, 32'h0);
        wr(5'h00, 32'h0000_000F);
        wait_cirq();
        wr(5'h00, 32'h0000_000E);
        rd(5'h08);
        c = r;
        chk("reload bound", c <= 32'h3, 1'b1);
        rd(5'h08);
        chk("hold", r, c);
        wr(5'h00, 32'h0000_000C);
        chk("ie off", counter_irq, 1'b0);
        wr(5'h00, 32'h0000_000E);
        chk("ie on", counter_irq, 1'b1);
        wr(5'h04, 32'h1);
        chk("w1 keeps", counter_irq, 1'b1);
        wr(5'h04, 32'h0);
        chk("w0 clears", counter_irq, 1'b0);
    endtask

    task automatic t_down;
        wr(5'h08, 32'h5);
        wr(5'h00, 32'h0000_0017);
        wait_cirq();
        wr(5'h00, 32'h0);
        rd(5'h08);
        chk("down wrap", r[31], 1'b1);
        wr(5'h04, 32'h0);
    endtask

    task automatic t_div;
        wr(5'h08, 32'h0);
        wr(5'h00, 32'h0000_0001);
        repeat (24) @(posedge ref_clk);
        wr(5'h00, 32'h0);
        rd(5'h08);
        chk("div8", r >= 32'h2 && r <= 32'h4, 1'b1);
        wr(5'h08, 32'h0);
        wr(5'h00, 32'h0000_0005);
        repeat (24) @(posedge ref_clk);
        wr(5'h00, 32'h0);
        rd(5'h08);
        chk("direct", r >= 32'h18 && r <= 32'h1E, 1'b1);
    endtask

    task automatic t_irq;
        chk("masked", irq, 1'b0);
        rd(5'h14);
        chk("cmp event", r, 32'h3);
        wr(5'h18, 32'h3);
        wr(5'h00, 32'h8000_0000);
        wr(5'h00, 32'h0);
        chk("irq on", irq, 1'b1);
        rd(5'h14);
        chk("swi event", r, 32'h2);
        rd(5'h14);
        chk("read clr", r, 32'h0);
        chk("irq off", irq, 1'b0);
        wr(5'h18, 32'h0);
        wr(5'h04, 32'h8000_0000);
        wr(5'h04, 32'h0);
        chk("mask", irq, 1'b0);
        rd(5'h14);
        chk("masked evt", r, 32'h2);
    endtask

    initial begin
        fail_count = 0;
        tests_run = 0;
        rst = 1'b1;
        avs_address = 5'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_up();
        t_down();
        t_div();
        t_irq();
        complete_run();
    end
endmodule

`default_nettype wire
